// >>> core/agc_gpio_config.sv
`timescale 1ns/1ps
module agc_gpio_config (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        chipSelectN,
  input  wire logic        serialClock,
  input  wire logic        serialIn,
  output logic             serialOut,
  input  wire logic [3:0]  pinIn,
  output logic      [3:0]  pinOut,
  output logic      [3:0]  pinOutEnable,
  input  wire logic        highAlarm,
  input  wire logic        lowAlarm,
  input  wire logic [11:0] conversionWord,
  output logic             rangeSelect,
  output logic             powerDown,
  output logic             deviceResetPulse
);
  agc_pkg::agc_state_t state;
  agc_pkg::agc_state_t next_state;
  logic [15:0] shiftIn;
  logic [4:0]  bitCount;
  logic [9:0]  configWord;
  logic [3:0]  gpoPending;
  logic [3:0]  gpoLive;
  logic        readbackEnable;
  logic        modePowerDown;
  logic [15:0] outShift;
  logic        pdLatched;
  logic [6:0]  syncLevel;
  logic [6:0]  syncRise;
  logic [6:0]  syncFall;

  function automatic logic [3:0] specialMask(input logic [9:0] cfg);
    logic [2:0] sel;
    sel = cfg[agc_pkg::ALARM_MSB:agc_pkg::ALARM_LSB];
    specialMask = {cfg[agc_pkg::PD_ASSIGN_BIT], cfg[agc_pkg::RANGE_ASSIGN_BIT],
                   sel[2] & ~sel[0], sel[0] | sel[1]};
  endfunction

  agc_pin_sync #(
    .WIDTH       (agc_pkg::SYNC_WIDTH),
    .RESET_LEVEL (agc_pkg::SYNC_RESET)
  ) u_sync (
    .clock   (clock),
    .reset   (reset),
    .asyncIn ({pinIn, serialIn, serialClock, chipSelectN}),
    .level   (syncLevel),
    .rise    (syncRise),
    .fall    (syncFall)
  );

  wire       csFall    = syncFall[0];
  wire       csRise    = syncRise[0];
  wire       sclkRise  = syncRise[1];
  wire       sclkFall  = syncFall[1];
  wire       sdiLevel  = syncLevel[2];
  wire [3:0] pinLevel  = syncLevel[6:3];
  wire       inFrame   = (state == agc_pkg::AGC_FRAME);
  wire [3:0] command   = shiftIn[agc_pkg::CMD_MSB:agc_pkg::CMD_LSB];
  wire       frameGood = csRise && inFrame && (bitCount == agc_pkg::FRAME_COUNT);
  wire       cfgFrame  = frameGood && (command == agc_pkg::CMD_PIN_CONFIG);
  wire       modeFrame = frameGood && (command >= agc_pkg::CMD_MODE_FIRST)
                         && (command <= agc_pkg::CMD_MODE_LAST);
  wire       resetAll  = reset || (csFall && configWord[agc_pkg::RESET_REQ_BIT]);
  wire [2:0] alarmSel  = configWord[agc_pkg::ALARM_MSB:agc_pkg::ALARM_LSB];
  wire [3:0] special   = specialMask(configWord);
  wire [3:0] direction = configWord[agc_pkg::DIR_MSB:0];
  wire       pdAssign  = configWord[agc_pkg::PD_ASSIGN_BIT];
  wire       rangeAssign = configWord[agc_pkg::RANGE_ASSIGN_BIT];
  // xx1 gives either alarm on pin zero, x10 puts the high alarm on pin zero
  wire       pin0Alarm = alarmSel[0] ? (highAlarm | lowAlarm) : highAlarm;
  wire [3:0] alarmLevel = {2'b00, lowAlarm, pin0Alarm};
  wire [3:0] next_pinOutEnable = (special & {2'b00, special[1:0]})
                                 | (~special & direction);
  wire [3:0] next_pinOut = (special & alarmLevel) | (~special & direction & gpoLive);
  wire [15:0] loadWord = {conversionWord, readbackEnable ? pinLevel : 4'h0};
  wire       next_readback = modeFrame ? shiftIn[agc_pkg::READBACK_BIT] : readbackEnable;

  always_comb begin
    case (state)
      agc_pkg::AGC_IDLE:  next_state = csFall ? agc_pkg::AGC_FRAME : agc_pkg::AGC_IDLE;
      agc_pkg::AGC_FRAME: next_state = csRise ? agc_pkg::AGC_IDLE : agc_pkg::AGC_FRAME;
      default:            next_state = agc_pkg::AGC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= agc_pkg::AGC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // msb first, sampled on serial clock rise, extra bits beyond sixteen ignored
  always_ff @(posedge clock) begin
    if (reset || csFall) begin
      shiftIn  <= 16'h0000;
      bitCount <= 5'h00;
    end else if (inFrame && sclkRise && bitCount < agc_pkg::FRAME_COUNT) begin
      shiftIn  <= {shiftIn[14:0], sdiLevel};
      bitCount <= bitCount + 5'h01;
    end
  end

  // only bits 9:0 are kept, the host keeps 11:10 at zero
  always_ff @(posedge clock) begin
    if (resetAll) begin
      configWord <= agc_pkg::CONFIG_RESET;
    end else if (cfgFrame) begin
      configWord <= shiftIn[agc_pkg::CFG_MSB:0];
    end
  end

  // config frames never touch output data or readback/power settings
  always_ff @(posedge clock) begin
    if (resetAll) begin
      gpoPending     <= agc_pkg::GPO_RESET;
      readbackEnable <= 1'b0;
      modePowerDown  <= 1'b0;
    end else if (modeFrame) begin
      gpoPending     <= shiftIn[agc_pkg::GPO_MSB:0];
      readbackEnable <= next_readback;
      modePowerDown  <= shiftIn[agc_pkg::MODE_PD_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (resetAll) begin
      gpoLive <= agc_pkg::GPO_RESET;
    end else if (csFall) begin
      gpoLive <= gpoPending;
    end
  end

  // output word loaded at chip-select fall, advanced on serial clock fall
  always_ff @(posedge clock) begin
    if (reset) begin
      outShift  <= 16'h0000;
      serialOut <= 1'b0;
    end else if (csFall) begin
      outShift  <= loadWord;
      serialOut <= loadWord[15];
    end else if (inFrame && sclkFall) begin
      outShift  <= {outShift[14:0], 1'b0};
      serialOut <= outShift[14];
    end
  end

  // set wins over the wake-up at the same edge
  always_ff @(posedge clock) begin
    if (resetAll) begin
      pdLatched <= 1'b0;
    end else if (pdAssign && !pinLevel[3]) begin
      pdLatched <= 1'b1;
    end else if (csFall && pinLevel[3] && !modePowerDown) begin
      pdLatched <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (resetAll) begin
      pinOut           <= 4'h0;
      pinOutEnable     <= 4'h0;
      rangeSelect      <= 1'b0;
      deviceResetPulse <= !reset;
    end else begin
      pinOut           <= next_pinOut;
      pinOutEnable     <= next_pinOutEnable;
      rangeSelect      <= rangeAssign & pinLevel[2];
      deviceResetPulse <= 1'b0;
    end
  end

  // raw pin path so power-down does not wait for the synchroniser
  assign powerDown = pdLatched | (pdAssign & ~pinIn[3]);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  AST_CONFIG_TAKEN: assert property (
    cfgFrame |=> configWord == $past(shiftIn[9:0]))
    else $error("configuration word not taken");
  AST_SHORT_FRAME: assert property (
    csRise && inFrame && bitCount != agc_pkg::FRAME_COUNT |=> $stable(configWord))
    else $error("short frame altered configuration");
  AST_GPO_UPDATE: assert property (
    csFall && !resetAll |=> gpoLive == $past(gpoPending))
    else $error("output data not refreshed at chip-select fall");
  AST_CONFIG_KEEPS_DATA: assert property (
    cfgFrame |=> $stable(gpoPending) && $stable(readbackEnable))
    else $error("config frame changed output data");
  AST_READBACK: assert property (
    csFall && readbackEnable |=> outShift[3:0] == $past(pinLevel) && serialOut == outShift[15])
    else $error("captured inputs not loaded for readback");
  AST_FULL_RESET: assert property (
    csFall && configWord[agc_pkg::RESET_REQ_BIT] |=> configWord == agc_pkg::CONFIG_RESET
      && deviceResetPulse ##1 !deviceResetPulse)
    else $error("full reset request not honoured");
  AST_PD_PIN_INPUT: assert property (
    pdAssign |=> !pinOutEnable[3])
    else $error("power-down pin driven");
  AST_RANGE_PIN_INPUT: assert property (
    rangeAssign ##1 rangeAssign |-> !pinOutEnable[2] && rangeSelect == $past(pinLevel[2]))
    else $error("range pin misbehaves");
  AST_ALARM_BOTH: assert property (
    alarmSel == agc_pkg::ALARM_BOTH && !resetAll |=> pinOutEnable[1:0] == 2'b11
      && pinOut[1:0] == {$past(lowAlarm), $past(highAlarm)})
    else $error("alarm routing wrong");
  AST_ALARM_ANY: assert property (
    alarmSel[0] && (highAlarm || lowAlarm) && !resetAll |=> pinOut[0])
    else $error("any-alarm output not high");
  AST_DIRECTION: assert property (
    !special[1] && !resetAll |=> pinOutEnable[1] == $past(direction[1])
      && pinOut[1] == ($past(direction[1]) && $past(gpoLive[1])))
    else $error("free pin direction wrong");
  AST_PD_ASYNC: assert property (
    pdAssign && !pinIn[3] |-> powerDown)
    else $error("power-down pin low but not powered down");
  AST_RESET_STATE: assert property (
    $fell(reset) |-> configWord == agc_pkg::CONFIG_RESET && pinOutEnable == 4'h0)
    else $error("pins not free inputs after reset");
endmodule

// >>> core/agc_pin_sync.sv
`timescale 1ns/1ps
module agc_pin_sync #(
  parameter int               WIDTH       = 7,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // a change counts only once stages two and three agree
  wire [WIDTH-1:0] settled = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] next_level = (settled & stage3) | (~settled & level);

  always_ff @(posedge clock) begin
    if (reset) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
      level  <= RESET_LEVEL;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign rise = next_level & ~level;
  assign fall = ~next_level & level;
endmodule

// >>> core/agc_pkg.sv
package agc_pkg;
  localparam int        FRAME_BITS       = 16;
  localparam logic [4:0] FRAME_COUNT     = 5'h10;
  localparam int        CMD_MSB          = 15;
  localparam int        CMD_LSB          = 12;
  localparam logic [3:0] CMD_PIN_CONFIG  = 4'h4;
  localparam logic [3:0] CMD_MODE_FIRST  = 4'h1;
  localparam logic [3:0] CMD_MODE_LAST   = 4'h3;
  localparam int        CFG_MSB          = 9;
  localparam int        RESET_REQ_BIT    = 9;
  localparam int        PD_ASSIGN_BIT    = 8;
  localparam int        RANGE_ASSIGN_BIT = 7;
  localparam int        ALARM_MSB        = 6;
  localparam int        ALARM_LSB        = 4;
  localparam int        DIR_MSB          = 3;
  localparam int        READBACK_BIT     = 4;
  localparam int        MODE_PD_BIT      = 5;
  localparam int        GPO_MSB          = 3;
  localparam logic [9:0] CONFIG_RESET    = 10'h000;
  localparam logic [3:0] GPO_RESET       = 4'h0;
  localparam logic [2:0] ALARM_NONE      = 3'h0;
  localparam logic [2:0] ALARM_BOTH      = 3'h6;
  localparam logic [6:0] SYNC_RESET      = 7'h01;
  localparam int        SYNC_WIDTH       = 7;

  typedef enum logic [1:0] {
    AGC_IDLE  = 2'b01,
    AGC_FRAME = 2'b10
  } agc_state_t;
endpackage

// >>> sim/agc_host_model.sv
`timescale 1ns/1ps
module agc_host_model (
  input  wire logic clock,
  output logic      chipSelectN,
  output logic      serialClock,
  output logic      serialIn,
  input  wire logic serialOut
);
  initial begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    serialIn    = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // serial clock stands still outside frames; short frames stop clocking early
  task automatic frame(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
    rx          = 16'h0000;
    chipSelectN = 1'b0;
    serialIn    = tx[15];
    wait_clk(8);
    for (int i = 15; i > 15 - nBits; i--) begin
      wait_clk(4);
      serialClock = 1'b1;
      wait_clk(4);
      rx[i]       = serialOut; // late in the high phase, bit has settled
      serialClock = 1'b0;
      // released data line toggles so a stale level never looks valid
      serialIn    = (i > 16 - nBits) ? tx[i-1] : ~serialIn;
    end
    wait_clk(4);
    chipSelectN = 1'b1;
    wait_clk(10);
  endtask
endmodule

// >>> sim/test_adc_gpio_config_and_io.sv
`timescale 1ns/1ps
module test_adc_gpio_config_and_io;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        chipSelectN;
  logic        serialClock;
  logic        serialIn;
  logic        serialOut;
  logic [3:0]  pinIn = 4'h0;
  logic [3:0]  pinOut;
  logic [3:0]  pinOutEnable;
  logic        highAlarm = 1'b0;
  logic        lowAlarm = 1'b0;
  logic [11:0] conversionWord = 12'h000;
  logic        rangeSelect;
  logic        powerDown;
  logic        deviceResetPulse;
  logic [15:0] rx;
  logic [9:0]  cfg = 10'h000;
  logic [3:0]  data = 4'h0;
  logic        rb;
  int          nMismatch = 0;
  int          nChecks = 0;
  int          nPulse = 0;
  logic [2:0]  alarmCodes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};

  always #5 clock = ~clock;
  always @(posedge clock) if (deviceResetPulse === 1'b1) nPulse++;

  agc_gpio_config u_dut (.clock(clock), .reset(reset), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialIn(serialIn), .serialOut(serialOut), .pinIn(pinIn),
    .pinOut(pinOut), .pinOutEnable(pinOutEnable), .highAlarm(highAlarm),
    .lowAlarm(lowAlarm), .conversionWord(conversionWord), .rangeSelect(rangeSelect),
    .powerDown(powerDown), .deviceResetPulse(deviceResetPulse));

  agc_host_model u_host (.clock(clock), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialIn(serialIn), .serialOut(serialOut));

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    nChecks++;
    if (seen !== expected) begin
      nMismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  function automatic logic [7:0] exp_pins(input logic [9:0] c, input logic [3:0] d,
                                          input logic hi, input logic lo);
    logic [3:0] en;
    logic [3:0] val;
    logic [2:0] al;
    al  = c[6:4];
    en  = c[3:0];
    val = d;
    if (al[0] || al == 3'h2 || al == 3'h6) begin
      en[0]  = 1'b1;
      val[0] = al[0] ? (hi | lo) : hi;
    end
    if (al == 3'h4 || al == 3'h6) begin
      en[1]  = 1'b1;
      val[1] = lo;
    end
    if (c[7]) en[2] = 1'b0;
    if (c[8]) en[3] = 1'b0;
    return {en, val & en};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic send(input logic [15:0] tx);
    u_host.frame(tx, 16, rx);
  endtask

  task automatic send_cfg();
    send({agc_pkg::CMD_PIN_CONFIG, 2'b00, cfg});
  endtask

  task automatic pins_check();
    check({8'h00, pinOutEnable, pinOut & pinOutEnable},
          {8'h00, exp_pins(cfg, data, highAlarm, lowAlarm)});
  endtask

  task automatic wrap_up();
    if (nMismatch == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(14385));
    step(5);
    reset = 1'b0;
    step(4);
    pins_check();
    check({14'h0000, powerDown, rangeSelect}, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      data = 4'($urandom);
      rb = 1'(i);
      pinIn = 4'($urandom);
      {highAlarm, lowAlarm} = 2'($urandom);
      conversionWord = 12'($urandom);
      cfg = {3'h0, alarmCodes[i % 6], 4'($urandom)};
      send({4'(1 + i % 3), 6'h00, 1'b0, rb, data});
      send_cfg();
      check(rx, {conversionWord, rb ? pinIn : 4'h0});
      pins_check();
      {highAlarm, lowAlarm} = ~{highAlarm, lowAlarm};
      step(3);
      pins_check();
    end
    // fifteen clocks only: whole direction change must be ignored
    u_host.frame({agc_pkg::CMD_PIN_CONFIG, 12'h00F}, 15, rx);
    pins_check();
    pinIn = 4'hC;
    cfg = 10'h18F;
    send_cfg();
    pins_check();
    check({15'h0000, rangeSelect}, 16'h0001);
    pinIn = 4'h0;
    #1;
    check({15'h0000, powerDown}, 16'h0001);
    step(6);
    check({14'h0000, powerDown, rangeSelect}, 16'h0002);
    pinIn = 4'h8;
    step(6);
    check({15'h0000, powerDown}, 16'h0001);
    send({4'h1, 6'h00, 1'b0, 1'b0, data});
    check({15'h0000, powerDown}, 16'h0000);
    cfg = 10'h20F;
    send_cfg();
    check(16'(nPulse), 16'h0000);
    send({4'h1, 12'h00A});
    cfg = 10'h000;
    data = 4'h0;
    check(16'(nPulse), 16'h0001);
    pins_check();
    wrap_up();
  end

  // twenty-nine frames of some 150 cycles each fit well inside this span
  initial begin
    #300_000;
    nMismatch++;
    wrap_up();
  end
endmodule
